// ---- core/pdl_pkg.sv ----
// Purpose: Constants for the PLL divider programming and lock flag block
// Assumes: Avalon-MM word addressing by byte address, 32-bit data
// Notes: Control and bandwidth words sit beside the divider registers
package pdl_pkg;
   // Byte addresses of the register words
   localparam logic [7:0] ADDR_MUL_LOW = 8'h38;
   localparam logic [7:0] ADDR_MUL_HIGH = 8'h3C;
   localparam logic [7:0] ADDR_VCO_RANGE = 8'h40;
   localparam logic [7:0] ADDR_REF_DIV = 8'h44;
   localparam logic [7:0] ADDR_CTRL = 8'h48;
   localparam logic [7:0] ADDR_BW = 8'h4C;
   localparam logic [7:0] ADDR_SYS = 8'h50;
   // Reset values
   localparam logic [7:0] RST_MUL_LOW = 8'h40;
   localparam logic [3:0] RST_MUL_HIGH = 4'h0;
   localparam logic [7:0] RST_VCO_RANGE = 8'h40;
   localparam logic [3:0] RST_REF_DIV = 4'h1;
   // Control word bit positions
   localparam int CTRL_IRQ_EN = 7;
   localparam int CTRL_FLAG = 6;
   localparam int CTRL_PLL_EN = 5;
   localparam int CTRL_BCS = 4;
   // Bandwidth word bit positions
   localparam int BW_AUTO = 7;
   localparam int BW_LOCK = 6;
   // System word bit positions
   localparam int SYS_OSC_KEEP = 1;
   localparam int SYS_BRK_CLR = 0;
endpackage

// ---- core/pdl_pll_divider.sv ----
// Purpose: Divider program registers, lock change flag and base clock select
// Assumes: Lock, break and stop arrive as pins from other logic
// Notes: Read data valid the cycle waitrequest drops
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module pdl_pll_divider (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic lock_in,
   input wire logic break_in,
   input wire logic stop_in,
   input wire logic wait_in,
   input wire logic xtal_clk_in,
   input wire logic vco_clk_in,
   output logic [11:0] feedback_divide,
   output logic [7:0] vco_range,
   output logic [3:0] ref_divide,
   output logic pll_active,
   output logic osc_active,
   output logic base_clock_select,
   output logic base_clock_out,
   output logic crystal_clock,
   output logic clockgen_irq_out
);
   // Register state
   logic [7:0] mul_low_ff, nxt_mul_low;
   logic [3:0] mul_high_ff, nxt_mul_high;
   logic [7:0] vco_range_ff, nxt_vco_range;
   logic [3:0] ref_div_ff, nxt_ref_div;
   logic irq_en_ff, nxt_irq_en;
   logic flag_ff, nxt_flag;
   logic pll_en_ff, nxt_pll_en;
   logic bcs_ff, nxt_bcs;
   logic auto_ff, nxt_auto;
   logic osc_keep_ff, nxt_osc_keep;
   logic brk_clr_ff, nxt_brk_clr;
   logic [31:0] rdata_ff, nxt_rdata;
   logic wait_ff, nxt_wait;
   // Pin synchronisers and derived outputs
   logic [2:0] lock_sy_ff, brk_sy_ff, stop_sy_ff, xt_sy_ff, vc_sy_ff;
   logic lock_q_ff, nxt_lock_q;
   logic brk_q_ff, nxt_brk_q;
   logic stop_q_ff, nxt_stop_q;
   logic xt_q_ff, nxt_xt_q;
   logic vc_q_ff, nxt_vc_q;
   logic half_ff, nxt_half;
   logic src_d_ff, nxt_src_d;
   logic [11:0] fb_ff, nxt_fb;
   logic [3:0] rd_ff, nxt_rd;
   logic pll_act_ff, nxt_pll_act;
   logic osc_act_ff, nxt_osc_act;
   logic xclk_ff, nxt_xclk;
   logic irq_ff, nxt_irq;
   logic bout_ff, nxt_bout;
   logic acc, wr_hit, rd_hit, stop_edge, lock_edge, protect;
   logic [11:0] rd_wide;

   // Zero divide value means one
   function automatic logic [11:0] zero_is_one(input logic [11:0] v);
      zero_is_one = (v == 12'h000) ? 12'h001 : v;
   endfunction

   // Access strobe; each access takes two cycles (wait then done)
   assign acc = (avs_read | avs_write) & wait_ff;
   assign wr_hit = avs_write & ~wait_ff & avs_byteenable[0];
   assign rd_hit = avs_read & ~wait_ff;
   assign protect = brk_q_ff & ~brk_clr_ff;
   // Stop entry is the rising edge of the filtered level
   assign stop_edge = ~stop_q_ff & nxt_stop_q;
   assign lock_edge = lock_q_ff ^ nxt_lock_q;

   // Pin synchronisers, three stages
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         lock_sy_ff <= 3'h0;
         brk_sy_ff <= 3'h0;
         stop_sy_ff <= 3'h0;
         xt_sy_ff <= 3'h0;
         vc_sy_ff <= 3'h0;
      end else begin
         lock_sy_ff <= {lock_sy_ff[1:0], lock_in};
         brk_sy_ff <= {brk_sy_ff[1:0], break_in};
         stop_sy_ff <= {stop_sy_ff[1:0], stop_in};
         xt_sy_ff <= {xt_sy_ff[1:0], xtal_clk_in};
         vc_sy_ff <= {vc_sy_ff[1:0], vco_clk_in};
      end
   end

   // Filtered levels change when stages two and three agree
   always_comb begin
      nxt_lock_q = (lock_sy_ff[1] == lock_sy_ff[2]) ? lock_sy_ff[2] : lock_q_ff;
      nxt_brk_q = (brk_sy_ff[1] == brk_sy_ff[2]) ? brk_sy_ff[2] : brk_q_ff;
      nxt_stop_q = (stop_sy_ff[1] == stop_sy_ff[2]) ? stop_sy_ff[2] : stop_q_ff;
      nxt_xt_q = (xt_sy_ff[1] == xt_sy_ff[2]) ? xt_sy_ff[2] : xt_q_ff;
      nxt_vc_q = (vc_sy_ff[1] == vc_sy_ff[2]) ? vc_sy_ff[2] : vc_q_ff;
   end
   // Wait mode input is accepted but has no effect on state
   logic unused_wait;
   assign unused_wait = wait_in;

   // Register file next state
   always_comb begin
      nxt_mul_low = mul_low_ff;
      nxt_mul_high = mul_high_ff;
      nxt_vco_range = vco_range_ff;
      nxt_ref_div = ref_div_ff;
      nxt_irq_en = irq_en_ff;
      nxt_flag = flag_ff;
      nxt_pll_en = pll_en_ff;
      nxt_bcs = bcs_ff;
      nxt_auto = auto_ff;
      nxt_osc_keep = osc_keep_ff;
      nxt_brk_clr = brk_clr_ff;
      nxt_wait = ~acc;
      nxt_rdata = rdata_ff;
      // Divider writes only while PLL off, else dropped silently
      if (wr_hit && !pll_en_ff) begin
         unique case (avs_address)
            pdl_pkg::ADDR_MUL_LOW: nxt_mul_low = avs_writedata[7:0];
            pdl_pkg::ADDR_MUL_HIGH: nxt_mul_high = avs_writedata[3:0];
            pdl_pkg::ADDR_VCO_RANGE: nxt_vco_range = avs_writedata[7:0];
            pdl_pkg::ADDR_REF_DIV: nxt_ref_div = avs_writedata[3:0];
            default: ;
         endcase
      end
      if (wr_hit && avs_address == pdl_pkg::ADDR_BW) begin
         nxt_auto = avs_writedata[pdl_pkg::BW_AUTO];
      end
      if (wr_hit && avs_address == pdl_pkg::ADDR_SYS) begin
         nxt_osc_keep = avs_writedata[pdl_pkg::SYS_OSC_KEEP];
         nxt_brk_clr = avs_writedata[pdl_pkg::SYS_BRK_CLR];
      end
      if (wr_hit && avs_address == pdl_pkg::ADDR_CTRL) begin
         nxt_irq_en = avs_writedata[pdl_pkg::CTRL_IRQ_EN] & auto_ff;
         // Enable cannot drop while select held
         nxt_pll_en = avs_writedata[pdl_pkg::CTRL_PLL_EN] | bcs_ff;
         // Select needs enable and nonzero range; lock not checked
         nxt_bcs = avs_writedata[pdl_pkg::CTRL_BCS] & pll_en_ff
                   & (vco_range_ff != 8'h00);
      end
      if (!auto_ff) begin
         nxt_irq_en = 1'b0;
      end
      // Control read clears flag unless break protects it
      if (rd_hit && avs_address == pdl_pkg::ADDR_CTRL && !protect) begin
         nxt_flag = 1'b0;
      end
      if ((wr_hit && avs_address == pdl_pkg::ADDR_CTRL) && !protect) begin
         nxt_flag = 1'b0;
      end
      // Lock change sets flag in auto mode; set beats clear
      if (auto_ff && lock_edge) begin
         nxt_flag = 1'b1;
      end
      // Zero range forces PLL off and crystal select
      if (vco_range_ff == 8'h00) begin
         nxt_bcs = 1'b0;
      end
      // Stop entry drops select so crystal drives after recovery
      if (stop_edge) begin
         nxt_bcs = 1'b0;
      end
      // Read mux loads while waitrequest is high so data stands when it drops
      if (avs_read && wait_ff) begin
         nxt_rdata = 32'h0000_0000;
         unique case (avs_address)
            pdl_pkg::ADDR_MUL_LOW: nxt_rdata[7:0] = mul_low_ff;
            pdl_pkg::ADDR_MUL_HIGH: nxt_rdata[3:0] = mul_high_ff;
            pdl_pkg::ADDR_VCO_RANGE: nxt_rdata[7:0] = vco_range_ff;
            pdl_pkg::ADDR_REF_DIV: nxt_rdata[3:0] = ref_div_ff;
            pdl_pkg::ADDR_CTRL: begin
               nxt_rdata[pdl_pkg::CTRL_IRQ_EN] = irq_en_ff;
               nxt_rdata[pdl_pkg::CTRL_FLAG] = flag_ff & auto_ff;
               nxt_rdata[pdl_pkg::CTRL_PLL_EN] = pll_en_ff;
               nxt_rdata[pdl_pkg::CTRL_BCS] = bcs_ff;
            end
            pdl_pkg::ADDR_BW: begin
               nxt_rdata[pdl_pkg::BW_AUTO] = auto_ff;
               nxt_rdata[pdl_pkg::BW_LOCK] = lock_q_ff & auto_ff;
            end
            pdl_pkg::ADDR_SYS: begin
               nxt_rdata[pdl_pkg::SYS_OSC_KEEP] = osc_keep_ff;
               nxt_rdata[pdl_pkg::SYS_BRK_CLR] = brk_clr_ff;
            end
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   // Output and clock path next state
   always_comb begin
      nxt_fb = zero_is_one({mul_high_ff, mul_low_ff});
      rd_wide = zero_is_one({8'h00, ref_div_ff});
      nxt_rd = rd_wide[3:0];
      // PLL runs only when enabled, range nonzero and not stopped
      nxt_pll_act = pll_en_ff & (vco_range_ff != 8'h00) & ~stop_q_ff;
      nxt_osc_act = ~stop_q_ff | osc_keep_ff;
      nxt_xclk = xt_q_ff & nxt_osc_act;
      // Halve selected source on its rising edges
      nxt_src_d = bcs_ff ? vc_q_ff : xt_q_ff;
      nxt_half = half_ff;
      if (nxt_src_d && !src_d_ff) begin
         nxt_half = ~half_ff;
      end
      nxt_bout = half_ff & ~(stop_q_ff & ~osc_keep_ff);
      nxt_irq = flag_ff & irq_en_ff & auto_ff & ~(stop_q_ff & ~osc_keep_ff);
   end

   // Register all state except the pin synchroniser stages
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mul_low_ff <= pdl_pkg::RST_MUL_LOW;
         mul_high_ff <= pdl_pkg::RST_MUL_HIGH;
         vco_range_ff <= pdl_pkg::RST_VCO_RANGE;
         ref_div_ff <= pdl_pkg::RST_REF_DIV;
         irq_en_ff <= 1'b0;
         flag_ff <= 1'b0;
         pll_en_ff <= 1'b1;
         bcs_ff <= 1'b0;
         auto_ff <= 1'b0;
         osc_keep_ff <= 1'b0;
         brk_clr_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         wait_ff <= 1'b1;
         lock_q_ff <= 1'b0;
         brk_q_ff <= 1'b0;
         stop_q_ff <= 1'b0;
         xt_q_ff <= 1'b0;
         vc_q_ff <= 1'b0;
         half_ff <= 1'b0;
         src_d_ff <= 1'b0;
         fb_ff <= 12'h040;
         rd_ff <= 4'h1;
         pll_act_ff <= 1'b0;
         osc_act_ff <= 1'b1;
         xclk_ff <= 1'b0;
         irq_ff <= 1'b0;
         bout_ff <= 1'b0;
      end else begin
         mul_low_ff <= nxt_mul_low;
         mul_high_ff <= nxt_mul_high;
         vco_range_ff <= nxt_vco_range;
         ref_div_ff <= nxt_ref_div;
         irq_en_ff <= nxt_irq_en;
         flag_ff <= nxt_flag;
         pll_en_ff <= nxt_pll_en;
         bcs_ff <= nxt_bcs;
         auto_ff <= nxt_auto;
         osc_keep_ff <= nxt_osc_keep;
         brk_clr_ff <= nxt_brk_clr;
         rdata_ff <= nxt_rdata;
         wait_ff <= nxt_wait;
         lock_q_ff <= nxt_lock_q;
         brk_q_ff <= nxt_brk_q;
         stop_q_ff <= nxt_stop_q;
         xt_q_ff <= nxt_xt_q;
         vc_q_ff <= nxt_vc_q;
         half_ff <= nxt_half;
         src_d_ff <= nxt_src_d;
         fb_ff <= nxt_fb;
         rd_ff <= nxt_rd;
         pll_act_ff <= nxt_pll_act;
         osc_act_ff <= nxt_osc_act;
         xclk_ff <= nxt_xclk;
         irq_ff <= nxt_irq;
         bout_ff <= nxt_bout;
      end
   end

   // Outputs straight from flops
   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign feedback_divide = fb_ff;
   assign vco_range = vco_range_ff;
   assign ref_divide = rd_ff;
   assign pll_active = pll_act_ff;
   assign osc_active = osc_act_ff;
   assign base_clock_select = bcs_ff;
   assign base_clock_out = bout_ff;
   assign crystal_clock = xclk_ff;
   assign clockgen_irq_out = irq_ff;
endmodule // pdl_pll_divider
`default_nettype wire

// ---- sim/pdl_pll_divider_assertions.sv ----
// Purpose: Port checks on the PLL divider block
// Assumes: One clock, sync active low reset
// Notes: Bound from the testbench top file
`timescale 1ns/10ps
`default_nettype none
module pdl_pll_divider_checker (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [11:0] feedback_divide,
   input wire logic [7:0] vco_range,
   input wire logic [3:0] ref_divide,
   input wire logic pll_active,
   input wire logic base_clock_select,
   input wire logic stop_in
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Divider outputs and reset load
   fb_nonzero_a: assert property (feedback_divide != 12'h000)
      else $error("multiplier output zero");
   ref_nonzero_a: assert property (ref_divide != 4'h0)
      else $error("divider output zero");
   reset_load_a: assert property ($rose(rst_n) |-> feedback_divide == 12'h040
      && vco_range == 8'h40 && ref_divide == 4'h1) else $error("bad reset load");
   // Range zero interlocks, and range changes only after a write
   range_pll_a: assert property (vco_range == 8'h00 |-> !pll_active)
      else $error("pll on with range zero");
   range_sel_a: assert property (vco_range == 8'h00 |-> !base_clock_select)
      else $error("select with range zero");
   range_hold_a: assert property ($changed(vco_range) |-> $past(avs_write)
      || $past(avs_write, 2)) else $error("range moved without write");
   // Stop handling
   stop_sel_a: assert property ($rose(stop_in) |-> ##[1:8] !base_clock_select)
      else $error("select kept in stop");
   stop_pll_a: assert property (stop_in [*8] |-> !pll_active)
      else $error("pll on in stop");
   // Bus answer timing
   bus_ack_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
      else $error("late answer");
   cover property ($rose(base_clock_select));
   cover property ($rose(stop_in));
   cover property (vco_range == 8'h00);
endmodule // pdl_pll_divider_checker
`default_nettype wire

// ---- sim/pdl_pll_divider_tb.sv ----
// Purpose: Self-checking bench for the PLL divider block
// Assumes: Avalon-MM master in bench tasks
// Notes: Sync pins settle within eight cycles
`timescale 1ns/10ps
`default_nettype none
module pdl_pll_divider_tb;
   logic sys_clk, rst_n, avs_read, avs_write, lock_in, break_in, stop_in, wait_in;
   logic xtal_clk_in, vco_clk_in, avs_waitrequest, pll_active, osc_active;
   logic base_clock_select, base_clock_out, crystal_clock, clockgen_irq_out;
   logic [7:0] avs_address, vco_range;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0] avs_byteenable, ref_divide;
   logic [11:0] feedback_divide;
   int n_errors = 0;
   int checks_done = 0;
   pdl_pll_divider i_pdl_pll_divider (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .lock_in, .break_in,
      .stop_in, .wait_in, .xtal_clk_in, .vco_clk_in, .feedback_divide, .vco_range,
      .ref_divide, .pll_active, .osc_active, .base_clock_select, .base_clock_out,
      .crystal_clock, .clockgen_irq_out);
   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Source clocks at a half and a quarter of the bus clock
   always @(posedge sys_clk) begin
      xtal_clk_in <= ~xtal_clk_in;
      vco_clk_in <= vco_clk_in ^ xtal_clk_in;
   end
   task automatic summarize;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // One bus transfer, held until waitrequest is seen low
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_write <= w;
      avs_read <= !w;
      // Look mid-cycle where outputs are settled, release after next rising edge
      do begin
         @(negedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      chk(n < 20, 1'b1);
      q = avs_readdata;
      @(posedge sys_clk);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
      xfer(1'b0, a, 8'h00);
      chk(q & {24'h00_0000, m}, e);
   endtask
   task automatic settle;
      repeat (8) @(posedge sys_clk);
   endtask
   // Reset loads, then writes refused while the PLL is on
   task automatic t_locked_regs;
      rc(8'h38, 8'h40);
      rc(8'h3C, 8'h00);
      rc(8'h40, 8'h40);
      rc(8'h44, 8'h01);
      rc(8'h48, 8'h20, 8'h30);
      wr(8'h38, 8'h12);
      wr(8'h3C, 8'h05);
      wr(8'h40, 8'h11);
      wr(8'h44, 8'h03);
      rc(8'h38, 8'h40);
      rc(8'h3C, 8'h00);
      rc(8'h40, 8'h40);
      rc(8'h44, 8'h01);
      rc(8'h60, 8'h00);
   endtask
   // Divider programming with the PLL off
   task automatic t_program;
      wr(8'h48, 8'h00);
      wr(8'h38, 8'h00);
      wr(8'h3C, 8'hF0);
      rc(8'h3C, 8'h00);
      chk(feedback_divide, 12'h001);
      wr(8'h44, 8'hF0);
      rc(8'h44, 8'h00);
      chk(ref_divide, 4'h1);
      wr(8'h38, 8'h34);
      wr(8'h3C, 8'h12);
      rc(8'h38, 8'h34);
      chk(feedback_divide, 12'h234);
   endtask
   // Range zero, select interlocks, wait mode
   task automatic t_select;
      wr(8'h40, 8'h00);
      wr(8'h48, 8'h20);
      wr(8'h48, 8'h30);
      rc(8'h48, 8'h20, 8'h30);
      chk(pll_active, 1'b0);
      wr(8'h48, 8'h00);
      wr(8'h40, 8'h40);
      wr(8'h48, 8'h20);
      wr(8'h48, 8'h30);
      rc(8'h48, 8'h30, 8'h30);
      wr(8'h48, 8'h10);
      rc(8'h48, 8'h30, 8'h30);
      wait_in <= 1'b1;
      settle();
      chk(base_clock_select, 1'b1);
      wait_in <= 1'b0;
   endtask
   // Stop with and without the oscillator kept
   task automatic t_stop;
      stop_in <= 1'b1;
      settle();
      chk(base_clock_select, 1'b0);
      chk({osc_active, crystal_clock, base_clock_out, pll_active}, 4'h0);
      stop_in <= 1'b0;
      settle();
      chk(base_clock_select, 1'b0);
      wr(8'h50, 8'h02);
      stop_in <= 1'b1;
      settle();
      chk({osc_active, pll_active}, 2'b10);
      stop_in <= 1'b0;
      settle();
   endtask
   // Lock change flag, interrupt, break protection, manual mode
   task automatic t_lock;
      wr(8'h4C, 8'h80);
      wr(8'h48, 8'hA0);
      lock_in <= 1'b1;
      settle();
      chk(clockgen_irq_out, 1'b1);
      rc(8'h4C, 8'h40, 8'h40);
      rc(8'h48, 8'h40, 8'h40);
      rc(8'h48, 8'h00, 8'h40);
      chk(clockgen_irq_out, 1'b0);
      wr(8'h48, 8'h20);
      lock_in <= 1'b0;
      break_in <= 1'b1;
      settle();
      chk(clockgen_irq_out, 1'b0);
      rc(8'h48, 8'h40, 8'h40);
      rc(8'h48, 8'h40, 8'h40);
      wr(8'h50, 8'h01);
      rc(8'h48, 8'h40, 8'h40);
      break_in <= 1'b0;
      settle();
      rc(8'h48, 8'h00, 8'h40);
      wr(8'h4C, 8'h00);
      lock_in <= 1'b1;
      settle();
      rc(8'h48, 8'h00, 8'hC0);
      chk(clockgen_irq_out, 1'b0);
   endtask
   // Main sequence
   initial begin
      {rst_n, avs_read, avs_write, lock_in, break_in, stop_in, wait_in} = 7'h00;
      {xtal_clk_in, vco_clk_in, avs_address, avs_writedata} = 42'h0;
      avs_byteenable = 4'hF;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      t_locked_regs();
      t_program();
      t_select();
      t_stop();
      t_lock();
      summarize();
   end
   // Watchdog
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_errors++;
      summarize();
   end
endmodule // pdl_pll_divider_tb
bind pdl_pll_divider pdl_pll_divider_checker i_pdl_pll_divider_checker (.sys_clk, .rst_n,
   .avs_read, .avs_write, .avs_waitrequest, .feedback_divide, .vco_range, .ref_divide,
   .pll_active, .base_clock_select, .stop_in);
`default_nettype wire
